// [bench/frs_ramp_select_tb.sv]
// Purpose: self-checking bench for the ramp select block
// Assumes: apb answers after one wait state, ramp tick 2500 cycles
// Notes:   short ramp times keep every ramp to a few steps
`timescale 1ns/1ps
`default_nettype none

module frs_ramp_select_tb;
    import frs_pkg::*;

    logic        core_clk, rstn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e;
    logic        run_in, run_cfg, jog_in, din_one, din_two, power_ok;
    logic        bus_over, at_speed, running, dc_brake_on, db_gate;
    logic        nvm_store, prog_mode, key_up, key_down, key_enter, key_esc;
    logic [15:0] ext_freq, out_freq, dc_brake_amps;
    int          err_total = 0;
    int          n_tests   = 0;
    // index and value pairs of the run setup
    int cfg_i [10] = '{IDX_MAXF, IDX_ACC1, IDX_DEC1, IDX_ACC2, IDX_DEC2,
                       IDX_SRC, IDX_PRE0 + 1, IDX_PRE0 + 3, IDX_JOGF,
                       IDX_JOGR};
    int cfg_v [10] = '{4000, 1, 1, 1, 1, 4, 2, 1, 3, 1};

    frs_ramp_select frs_ramp_select_i (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_in(run_in),
        .run_cfg(run_cfg), .jog_in(jog_in), .din_one(din_one),
        .din_two(din_two), .power_ok(power_ok), .bus_over(bus_over),
        .ext_freq(ext_freq), .prog_mode(prog_mode), .key_up(key_up),
        .key_down(key_down), .key_enter(key_enter), .key_esc(key_esc),
        .out_freq(out_freq), .at_speed(at_speed), .running(running),
        .dc_brake_on(dc_brake_on), .dc_brake_amps(dc_brake_amps),
        .db_gate(db_gate), .nvm_store(nvm_store));

    frs_terminals frs_terminals_i (
        .run_in(run_in), .run_cfg(run_cfg), .jog_in(jog_in),
        .din_one(din_one), .din_two(din_two), .power_ok(power_ok),
        .bus_over(bus_over), .ext_freq(ext_freq));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // one apb transfer, entered right after a rising edge
    task automatic apb(input logic w, input int idx, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= 12'(idx * 4);
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50)
        begin
            err_total++;
            $display("[FAIL] apb pready expected 1 seen 0");
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // wait for the output frequency, bounded
    task automatic wait_freq(input logic [15:0] v, input string nm);
        int n;
        n = 0;
        while (out_freq !== v && n < 40000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(nm, {16'h0000, v}, {16'h0000, out_freq});
        $display("test %s done", nm);
    endtask : wait_freq

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // ----------------------------------------------------------------
    // clock, reset, watchdog
    // ----------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (98000) @(posedge core_clk);
        err_total++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        rstn    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        prog_mode = 1'b0;
        key_up    = 1'b0;
        key_down  = 1'b0;
        key_enter = 1'b0;
        key_esc   = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        // reset values, then an unmapped word
        for (int i = 0; i < NREG; i++)
        begin
            apb(1'b0, i, 32'h0000_0000);
            chk("reg default", {16'h0000, CFG_RST[i]}, q);
        end
        chk("dc level", {16'h0000, CFG_RST[IDX_DCLVL]},
            {16'h0000, dc_brake_amps});
        apb(1'b0, 26, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        $display("test registers done");
        for (int i = 0; i < 10; i++)
            apb(1'b1, cfg_i[i], 32'(cfg_v[i]));
        // preset one under preset source, first ramp pair
        frs_terminals_i.put(1'b1, 1'b0, 2'b01, 1'b0);
        wait_freq(16'h0002, "preset one");
        // preset three, second ramp pair downwards
        frs_terminals_i.put(1'b1, 1'b0, 2'b11, 1'b0);
        wait_freq(16'h0001, "preset three");
        // jog overrides the preset and uses the jog ramp
        frs_terminals_i.put(1'b1, 1'b1, 2'b11, 1'b0);
        wait_freq(16'h0003, "jog");
        frs_terminals_i.put(1'b1, 1'b0, 2'b11, 1'b0);
        wait_freq(16'h0001, "jog release");
        // dynamic brake: full duty, then disabled
        apb(1'b1, IDX_DBSEL, 32'h0000_0002);
        frs_terminals_i.put(1'b1, 1'b0, 2'b11, 1'b1);
        repeat (300) @(posedge core_clk);
        chk("db full", 32'h0000_0001, {31'h0, db_gate});
        apb(1'b1, IDX_DBSEL, 32'h0000_0000);
        repeat (300) @(posedge core_clk);
        chk("db off", 32'h0000_0000, {31'h0, db_gate});
        $display("test brake done");
        // ramp stop into dc injection, then status word
        apb(1'b1, IDX_DCDUR, 32'h0000_0001);
        frs_terminals_i.put(1'b0, 1'b0, 2'b11, 1'b1);
        wait_freq(16'h0000, "ramp stop");
        repeat (2) @(posedge core_clk);
        chk("dc brake on", 32'h0000_0001, {31'h0, dc_brake_on});
        chk("stopped", 32'h0000_0000, {31'h0, running});
        repeat (4 * TICK_CYC) @(posedge core_clk);
        apb(1'b0, IDX_STAT, 32'h0000_0000);
        chk("status", 32'h0006_0000, q);
        // limited and protected duty modes, set while stopped
        apb(1'b1, IDX_DBDUT, 32'h0000_0063);
        apb(1'b1, IDX_DBSEL, 32'h0000_0003);
        repeat (3) @(posedge core_clk);
        chk("db limited", 32'h0000_0001, {31'h0, db_gate});
        apb(1'b1, IDX_DBSEL, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        chk("db protected", 32'h0000_0000, {31'h0, db_gate});
        $display("test stop done");
        // keypad: up, enter commits, down, escape restores
        apb(1'b1, IDX_SRC, 32'h0000_0001);
        prog_mode <= 1'b1;
        key_up    <= 1'b1;
        @(posedge core_clk);
        key_up    <= 1'b0;
        key_enter <= 1'b1;
        @(posedge core_clk);
        key_enter <= 1'b0;
        key_down  <= 1'b1;
        @(posedge core_clk);
        chk("nvm store", 32'h0000_0001, {31'h0, nvm_store});
        key_down  <= 1'b0;
        key_esc   <= 1'b1;
        @(posedge core_clk);
        key_esc   <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, IDX_WORK, 32'h0000_0000);
        chk("keypad esc", {16'h0000, CFG_RST[IDX_INTF] + 16'h0001}, q);
        apb(1'b0, IDX_INTF, 32'h0000_0000);
        chk("keypad enter", {16'h0000, CFG_RST[IDX_INTF] + 16'h0001}, q);
        $display("test keypad done");
        // run with the internal target inside the skip band
        apb(1'b1, IDX_SKIP, 32'h0000_003c);
        apb(1'b1, IDX_BAND, 32'h0000_0005);
        frs_terminals_i.put(1'b1, 1'b0, 2'b00, 1'b0);
        repeat (20) @(posedge core_clk);
        chk("running", 32'h0000_0001, {31'h0, running});
        $display("test skip done");
        stop_test();
    end
endmodule : frs_ramp_select_tb

`default_nettype wire

// [bench/frs_terminals.sv]
// Purpose: terminal and power stage model facing the ramp block
// Assumes: levels change by nonblocking assignment after a clock edge
// Notes:   power stays present, one run input is configured
`timescale 1ns/1ps
`default_nettype none

module frs_terminals
(
    // terminal levels
    output logic        run_in,
    output logic        run_cfg,
    output logic        jog_in,
    output logic        din_one,
    output logic        din_two,
    // power stage
    output logic        power_ok,
    output logic        bus_over,
    output logic [15:0] ext_freq
);
    // idle terminals, valid run contact wiring
    initial
    begin
        run_in   = 1'b0;
        run_cfg  = 1'b1;
        jog_in   = 1'b0;
        din_one  = 1'b0;
        din_two  = 1'b0;
        power_ok = 1'b1;
        bus_over = 1'b0;
        ext_freq = 16'h0000;
    end

    // restart settings are never touched; the brake selector is written while running
    task automatic put(input logic r, input logic j, input logic [1:0] d,
                       input logic b);
        run_in  <= r;
        jog_in  <= j;
        din_one <= d[0];
        din_two <= d[1];
        bus_over <= b;
    endtask : put
endmodule : frs_terminals

`default_nettype wire

// [logic/frs_pkg.sv]
// Purpose: constants for the drive frequency ramp select block
// Assumes: 250 MHz core clock, frequencies in 0.1 Hz, times in 0.1 s
// Notes:   register offsets are byte addresses of 32-bit words
`default_nettype none

package frs_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam int IDX_ACC1  = 0;    // accel_time_first
    localparam int IDX_DEC1  = 1;    // decel_time_first
    localparam int IDX_ACC2  = 2;    // accel_time_second
    localparam int IDX_DEC2  = 3;    // decel_time_second
    localparam int IDX_SCRV  = 4;    // s_curve_percent
    localparam int IDX_JOGF  = 5;    // jog_freq_setting
    localparam int IDX_JOGR  = 6;    // jog_ramp_time
    localparam int IDX_INTF  = 7;    // internal_freq_setting
    localparam int IDX_PRE0  = 8;    // preset_freq_zero .. three at 8..11
    localparam int IDX_SKIP  = 12;   // skip_freq_setting, whole hertz
    localparam int IDX_BAND  = 13;   // skip_band_width
    localparam int IDX_DCDUR = 14;   // dc_brake_duration
    localparam int IDX_DCLVL = 15;   // dc_brake_current_level, % rated
    localparam int IDX_DBSEL = 16;   // brake_resistor_select
    localparam int IDX_DBDUT = 17;   // brake_duty_limit
    localparam int IDX_RSTRT = 18;   // restart_on_power_return
    localparam int IDX_MAXF  = 19;   // max_output_freq
    localparam int IDX_STOP  = 20;   // stop_method_select
    localparam int IDX_SRC   = 21;   // speed_source_select
    localparam int IDX_DI1   = 22;   // digital_input_one_select
    localparam int IDX_DI2   = 23;   // digital_input_two_select
    localparam int NREG      = 24;
    localparam int IDX_STAT  = 24;   // status, read only
    localparam int IDX_WORK  = 25;   // keypad working frequency, read only

    // reset values in register index order
    localparam logic [15:0] CFG_RST [0:NREG-1] = '{
        16'h0064, 16'h0064, 16'h00c8, 16'h00c8, 16'h0000, 16'h0064,
        16'h0064, 16'h0258, 16'h0000, 16'h0032, 16'h0064, 16'h00c8,
        16'h0000, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0005,
        16'h0000, 16'h0258, 16'h0000, 16'h0000, 16'h0004, 16'h0004};

    // ----------------------------------------------------------------
    // codes and limits
    // ----------------------------------------------------------------
    localparam logic [15:0] SRC_INT    = 16'h0001;
    localparam logic [15:0] SRC_PRESET = 16'h0004;
    localparam logic [15:0] DI_PRESET  = 16'h0004;
    localparam logic [15:0] DI_RAMP2   = 16'h0005;
    localparam logic [15:0] STOP_RAMP  = 16'h0000;
    localparam logic [15:0] STOP_COAST = 16'h0001;
    localparam logic [15:0] STOP_DCB   = 16'h0002;
    localparam logic [15:0] DC_CONT    = 16'h03e7;   // 99.9 s
    localparam logic [15:0] DC_LVL_MAX = 16'h00b4;   // 180 % rated
    localparam logic [15:0] FREQ_MAX   = 16'h0fa0;   // 400.0 Hz
    localparam logic [6:0]  DB_PROT    = 7'h05;      // 5 % duty
    localparam logic [6:0]  DB_FULL    = 7'h64;      // 100 % duty
    localparam logic [6:0]  PCT_LAST   = 7'h63;      // pwm phase 0..99

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS       = 4;
    localparam int TICK_NS      = 10000;          // ramp tick, 10 us
    localparam int DS_NS        = 100000000;      // 0.1 s
    localparam int TICK_CYC     = TICK_NS / CLK_NS;
    localparam int TICKS_PER_DS = DS_NS / TICK_NS;
    localparam int S_HALF       = TICKS_PER_DS / 200;  // per 0.1 s per %

endpackage : frs_pkg

`default_nettype wire

// [logic/frs_ramp_select.sv]
// Purpose: frequency command select, ramp, skip, dc and dynamic brake
// Assumes: apb slave with one wait state, inputs synchronous to core_clk
// Notes:   ramp advances once per 10 us tick, one 0.1 Hz step at most
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - first accel time sets rise rate
// - first decel time sets fall rate
// - s-curve adds half time each end
// - jog drives jog frequency, capped at max
// - jog uses jog ramp both ways
// - source one takes internal frequency
// - keypad up/down changes command at once
// - enter commits, escape restores previous value
// - preset input code supplies preset frequency
// - input one low bit, two high
// - presets two, three use second ramps
// - second-ramp input forces second ramps
// - active preset overrides speed source
// - preset zero only under preset source
// - never rest at skip frequency
// - band widens skip both sides
// - dc brake timed, 99.9 continuous
// - dc brake current capped at level
// - brake selector decodes duty modes
// - selector three uses duty setting
// - power-up restart needs configured valid run
module frs_ramp_select
    import frs_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // drive terminals
    input  wire logic        run_in,
    input  wire logic        run_cfg,
    input  wire logic        jog_in,
    input  wire logic        din_one,
    input  wire logic        din_two,
    input  wire logic        power_ok,
    input  wire logic        bus_over,
    input  wire logic [15:0] ext_freq,
    // keypad
    input  wire logic        prog_mode,
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        key_enter,
    input  wire logic        key_esc,
    // drive outputs
    output logic      [15:0] out_freq,
    output logic             at_speed,
    output logic             running,
    output logic             dc_brake_on,
    output logic      [15:0] dc_brake_amps,
    output logic             db_gate,
    output logic             nvm_store
);

    typedef enum logic [3:0] {
        RS_HOLD = 4'b0001,
        RS_LEAD = 4'b0010,
        RS_RAMP = 4'b0100,
        RS_TAIL = 4'b1000
    } frs_state_e;

    function automatic logic [15:0] fmin(input logic [15:0] a,
                                         input logic [15:0] b);
        fmin = (a < b) ? a : b;
    endfunction : fmin

    function automatic logic [26:0] ticks_of(input logic [15:0] ds,
                                             input int         k);
        ticks_of = 27'(32'(ds) * k);
    endfunction : ticks_of

    logic [15:0] cfg [0:NREG-1];
    logic [15:0] int_work;
    logic [15:0] tgt, rt, base, skp, lo, hi, maxf;
    logic [26:0] den, half_s, racc, racc_sum, dwell;
    logic [13:0] tick_cnt, ds_cnt;
    logic [15:0] bk_cnt;
    logic [6:0]  pct, duty;
    logic [1:0]  pre_idx;
    logic        tick, ds_tick, acc_en, mapped, pre_act, sec, up;
    logic        drive_on, coast_now, armed, bk_pend, kp_en, wr_en;
    logic [9:0]  idx;
    logic [31:0] rd_val;
    frs_state_e  st;

    // ----------------------------------------------------------------
    // apb register file and keypad
    // ----------------------------------------------------------------
    assign acc_en = psel && penable && !pready;
    assign idx    = paddr[11:2];
    assign mapped = (paddr[1:0] == 2'b00) && (idx <= 10'(IDX_WORK));
    assign kp_en  = prog_mode && (cfg[IDX_SRC] == SRC_INT);
    // a write lands on the edge at which the master sees pready
    assign wr_en  = psel && penable && pready && pwrite && mapped;

    // read mux
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (idx < 10'(NREG))
            rd_val = {16'h0000, cfg[idx[4:0]]};
        else if (idx == 10'(IDX_STAT))
            rd_val = {13'h0000, at_speed, dc_brake_on, running, out_freq};
        else if (idx == 10'(IDX_WORK))
            rd_val = {16'h0000, int_work};
    end

    // bus writes, keypad edits, one wait state per access
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NREG; i++)
                cfg[i] <= CFG_RST[i];
            int_work  <= CFG_RST[IDX_INTF];
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            nvm_store <= 1'b0;
        end
        else
        begin
            pready    <= acc_en;
            nvm_store <= 1'b0;
            if (acc_en)
            begin
                pslverr <= !mapped;
                prdata  <= mapped ? rd_val : 32'h0000_0000;
            end
            if (wr_en && idx < 10'(NREG))
                cfg[idx[4:0]] <= pwdata[15:0];
            if (wr_en && idx == 10'(IDX_INTF))
                int_work <= pwdata[15:0];
            if (kp_en)
            begin
                if (key_up && int_work < FREQ_MAX)
                    int_work <= int_work + 16'h0001;
                else if (key_down && int_work != 16'h0000)
                    int_work <= int_work - 16'h0001;
                else if (key_enter)
                begin
                    cfg[IDX_INTF] <= int_work;
                    nvm_store     <= 1'b1;
                end
                else if (key_esc)
                    int_work <= cfg[IDX_INTF];
            end
        end
    end

    // ----------------------------------------------------------------
    // command selection
    // ----------------------------------------------------------------
    assign pre_idx = {din_two, din_one};
    assign pre_act = (cfg[IDX_DI1] == DI_PRESET)
                  || (cfg[IDX_DI2] == DI_PRESET);
    assign maxf    = fmin(cfg[IDX_MAXF], FREQ_MAX);
    assign drive_on = power_ok && ((run_in && armed) || jog_in);
    assign skp     = 16'(32'(cfg[IDX_SKIP]) * 10);
    assign lo      = (skp > cfg[IDX_BAND]) ? skp - cfg[IDX_BAND] : 16'h0000;
    assign hi      = skp + cfg[IDX_BAND];

    // target frequency
    always_comb
    begin
        base = (cfg[IDX_SRC] == SRC_INT) ? int_work : ext_freq;
        if (cfg[IDX_SRC] == SRC_PRESET || (pre_act && pre_idx != 2'b00))
            base = cfg[IDX_PRE0 + 32'(pre_idx)];
        if (jog_in)
            base = cfg[IDX_JOGF];
        tgt = fmin(base, maxf);
        if (skp != 16'h0000 && tgt >= lo && tgt <= hi)
            tgt = ((tgt < skp && lo != 16'h0000) || hi >= maxf)
                ? lo - 16'h0001 : hi + 16'h0001;
        tgt = fmin(tgt, maxf);
        if (!drive_on)
            tgt = 16'h0000;
    end

    // ramp time choice
    always_comb
    begin
        up  = out_freq < tgt;
        sec = ((pre_act || cfg[IDX_SRC] == SRC_PRESET) && din_two)
           || (cfg[IDX_DI1] == DI_RAMP2 && din_one)
           || (cfg[IDX_DI2] == DI_RAMP2 && din_two);
        if (jog_in)
            rt = cfg[IDX_JOGR];
        else if (up)
            rt = sec ? cfg[IDX_ACC2] : cfg[IDX_ACC1];
        else
            rt = sec ? cfg[IDX_DEC2] : cfg[IDX_DEC1];
    end

    assign den      = ticks_of(rt, TICKS_PER_DS);
    assign half_s   = 27'(32'(ticks_of(rt, S_HALF)) * cfg[IDX_SCRV]);
    assign racc_sum = racc + 27'(maxf);
    assign coast_now = !drive_on && (cfg[IDX_STOP] == STOP_COAST
                                  || cfg[IDX_STOP] == STOP_DCB);

    // ----------------------------------------------------------------
    // tick generators
    // ----------------------------------------------------------------
    assign tick    = (tick_cnt == 14'(TICK_CYC - 1));
    assign ds_tick = tick && (ds_cnt == 14'(TICKS_PER_DS - 1));

    // 10 us tick and 0.1 s prescale
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            tick_cnt <= 14'h0000;
            ds_cnt   <= 14'h0000;
        end
        else
        begin
            tick_cnt <= tick ? 14'h0000 : tick_cnt + 14'h0001;
            if (ds_tick)
                ds_cnt <= 14'h0000;
            else if (tick)
                ds_cnt <= ds_cnt + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // ramp engine
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            st       <= RS_HOLD;
            out_freq <= 16'h0000;
            racc     <= 27'h000_0000;
            dwell    <= 27'h000_0000;
            at_speed <= 1'b0;
        end
        else if (coast_now)
        begin
            st       <= RS_HOLD;
            out_freq <= 16'h0000;
            racc     <= 27'h000_0000;
            at_speed <= 1'b0;
        end
        else if (tick)
        begin
            case (st)
                RS_HOLD:
                begin
                    at_speed <= (out_freq == tgt);
                    if (out_freq != tgt)
                    begin
                        st    <= RS_LEAD;
                        dwell <= half_s;
                    end
                end
                RS_LEAD:
                begin
                    if (dwell == 27'h000_0000)
                        st <= RS_RAMP;
                    else
                        dwell <= dwell - 27'h000_0001;
                end
                RS_RAMP:
                begin
                    if (out_freq == tgt)
                    begin
                        st    <= RS_TAIL;
                        dwell <= half_s;
                        racc  <= 27'h000_0000;
                    end
                    else if (racc_sum >= den)
                    begin
                        racc     <= racc_sum - den;
                        out_freq <= up ? out_freq + 16'h0001
                                       : out_freq - 16'h0001;
                    end
                    else
                        racc <= racc_sum;
                end
                RS_TAIL:
                begin
                    if (dwell == 27'h000_0000)
                        st <= RS_HOLD;
                    else
                        dwell <= dwell - 27'h000_0001;
                end
                default:
                    st <= RS_HOLD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // run, restart and dc brake
    // ----------------------------------------------------------------
    // run arming after power return
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            armed   <= 1'b0;
            running <= 1'b0;
        end
        else
        begin
            running <= drive_on;
            if (!power_ok)
                armed <= 1'b0;
            else if (!run_in || (cfg[IDX_RSTRT][0] && run_cfg))
                armed <= 1'b1;
        end
    end

    // dc injection after stop
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dc_brake_on   <= 1'b0;
            bk_pend       <= 1'b0;
            bk_cnt        <= 16'h0000;
            dc_brake_amps <= 16'h0000;
        end
        else
        begin
            dc_brake_amps <= fmin(cfg[IDX_DCLVL], DC_LVL_MAX);
            if (drive_on)
            begin
                dc_brake_on <= 1'b0;
                bk_pend     <= 1'b0;
            end
            else if (running)
            begin
                bk_pend <= (cfg[IDX_STOP] == STOP_RAMP
                         || cfg[IDX_STOP] == STOP_DCB)
                        && cfg[IDX_DCDUR] != 16'h0000;
                bk_cnt  <= cfg[IDX_DCDUR];
            end
            else if (bk_pend && !dc_brake_on && out_freq == 16'h0000)
                dc_brake_on <= 1'b1;
            else if (dc_brake_on && ds_tick && cfg[IDX_DCDUR] != DC_CONT)
            begin
                if (bk_cnt <= 16'h0001)
                begin
                    dc_brake_on <= 1'b0;
                    bk_pend     <= 1'b0;
                end
                else
                    bk_cnt <= bk_cnt - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // dynamic brake duty
    // ----------------------------------------------------------------
    always_comb
    begin
        case (cfg[IDX_DBSEL][1:0])
            2'd1:    duty = DB_PROT;
            2'd2:    duty = DB_FULL;
            2'd3:    duty = cfg[IDX_DBDUT][6:0];
            default: duty = 7'h00;
        endcase
    end

    // 1 ms pwm frame of 100 ticks
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pct     <= 7'h00;
            db_gate <= 1'b0;
        end
        else
        begin
            if (tick)
                pct <= (pct == PCT_LAST) ? 7'h00 : pct + 7'h01;
            db_gate <= bus_over && (pct < duty);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_ramp_start;
        tick && !coast_now && st == RS_HOLD && out_freq != tgt;
    endsequence

    sequence s_ramp_step;
        tick && !coast_now && st == RS_RAMP && out_freq != tgt
            && racc_sum >= den;
    endsequence

    a_lead_dwell: assert property (s_ramp_start |=> st == RS_LEAD
        && dwell == $past(half_s)) else $error("lead dwell wrong");
    a_step_one: assert property (s_ramp_step |=> (out_freq
        == $past(out_freq) + 16'h0001) || (out_freq
        == $past(out_freq) - 16'h0001)) else $error("ramp step");
    a_jog_ramp: assert property (jog_in |-> rt
        == cfg[IDX_JOGR]) else $error("jog ramp time");
    a_second_up: assert property (!jog_in && up && sec |-> rt
        == cfg[IDX_ACC2]) else $error("second accel");
    a_skip_free: assert property (skp != 16'h0000 && drive_on
        |-> !(tgt >= lo && tgt <= hi)) else $error("skip target");
    a_key_up: assert property (kp_en && key_up
        && int_work < FREQ_MAX |=> int_work == $past(int_work)
        + 16'h0001) else $error("keypad up");
    a_esc_back: assert property (kp_en && key_esc && !key_up
        && !key_down && !key_enter && !wr_en
        |=> int_work == $past(cfg[IDX_INTF])) else $error("escape");
    a_brake_cap: assert property (##1 dc_brake_amps
        <= DC_LVL_MAX) else $error("brake level cap");
    a_db_off: assert property (cfg[IDX_DBSEL] == 16'h0000
        |=> !db_gate) else $error("db gate while off");
    a_apb_wait: assert property (acc_en |=> pready ##1 !pready)
        else $error("apb answer timing");

endmodule : frs_ramp_select

`default_nettype wire
